// ===== logic/fcpe_pkg.sv
// Purpose: Shared constants and types for the flash access and program/erase control block
// Assumes: 100 MHz system clock
// Notes: Times are kept in their printed units, cycle counts derive from them
package fcpe_pkg;

  localparam int CLK_MHZ = 100;

  // Program/erase timing, typical and worst case
  localparam real ERASE_TYP_MS = 7.0;
  localparam real ERASE_MAX_MS = 8.0;
  localparam real PROG_TYP_MS = 3.0;
  localparam real PROG_MAX_MS = 3.5;
  localparam int ERASE_TYP_CYCLES = int'($floor(ERASE_TYP_MS * 1.0E3 * CLK_MHZ));
  localparam int ERASE_MAX_CYCLES = int'($floor(ERASE_MAX_MS * 1.0E3 * CLK_MHZ));
  localparam int PROG_TYP_CYCLES = int'($floor(PROG_TYP_MS * 1.0E3 * CLK_MHZ));
  localparam int PROG_MAX_CYCLES = int'($floor(PROG_MAX_MS * 1.0E3 * CLK_MHZ));

  // Extra system clock cycles taken by the sequencer before each operation; the one finish cycle comes on top
  localparam int CTRL_OVERHEAD_CYCLES = 4;
  localparam int CNT_W = 24;

  // Wait-state configuration
  localparam int WS_W = 3;
  localparam int WS_F1_MHZ = 8;
  localparam int WS_F2_MHZ = 13;
  localparam int WS_F3_MHZ = 17;
  localparam logic [WS_W-1:0] WS_MIN_1 = 3'h1;
  localparam logic [WS_W-1:0] WS_MIN_2 = 3'h2;
  localparam logic [WS_W-1:0] WS_MIN_3 = 3'h3;
  localparam logic [WS_W-1:0] WS_MIN_4 = 3'h4;

  typedef enum logic [1:0] {PE_IDLE, PE_SETUP, PE_RUN, PE_FINISH} fcpe_pe_state_type;
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} fcpe_rd_state_type;

  // Least wait-state count that the flash needs at a given system clock
  function automatic logic [WS_W-1:0] fcpe_min_ws(input int mhz);
    if (mhz <= WS_F1_MHZ)
    begin
      return WS_MIN_1;
    end
    else if (mhz <= WS_F2_MHZ)
    begin
      return WS_MIN_2;
    end
    else if (mhz <= WS_F3_MHZ)
    begin
      return WS_MIN_3;
    end
    return WS_MIN_4;
  endfunction

endpackage

// ===== logic/fcpe_pe_if.sv
// Purpose: Handshake between the access controller and the program/erase sequencer
// Assumes: One clock domain
// Notes: start is a one-cycle pulse, done is high for the single finish cycle
interface fcpe_pe_if;
  logic start;
  logic erase;
  logic busy;
  logic done;

  modport ctrl (output start, output erase, input busy, input done);
  modport seq (input start, input erase, output busy, output done);
endinterface

// ===== logic/fcpe_pe_seq.sv
// Purpose: Program/erase sequencer timing one page program or sector erase
// Assumes: start only arrives while busy is low
// Notes: Setup overhead, run time counted in system clock cycles, then a one-cycle finish
module fcpe_pe_seq
  import fcpe_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_TYP_CYCLES,
  parameter int PROG_CYC = PROG_TYP_CYCLES
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Controller side
  fcpe_pe_if.seq pe
);

  // Elaboration-time refusal of run counts that the counter cannot hold
  if (ERASE_CYC < 1 || PROG_CYC < 1 || ERASE_CYC >= (1 << CNT_W) || PROG_CYC >= (1 << CNT_W))
  begin
    $error("fcpe_pe_seq: run cycle counts out of range");
  end

  fcpe_pe_state_type state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic erase_reg, erase_next;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    erase_next = erase_reg;
    case (state_reg)
      PE_IDLE:
      begin
        if (pe.start)
        begin
          state_next = PE_SETUP;
          erase_next = pe.erase;
          cnt_next = CNT_W'(CTRL_OVERHEAD_CYCLES - 1);
        end
      end
      PE_SETUP:
      begin
        if (cnt_reg == '0)
        begin
          state_next = PE_RUN;
          cnt_next = erase_reg ? CNT_W'(ERASE_CYC - 1) : CNT_W'(PROG_CYC - 1);
        end
        else
        begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      PE_RUN:
      begin
        if (cnt_reg == '0)
        begin
          state_next = PE_FINISH;
        end
        else
        begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      PE_FINISH:
      begin
        state_next = PE_IDLE;
      end
      default:
      begin
        state_next = PE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_reg <= PE_IDLE;
      cnt_reg <= '0;
      erase_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      erase_reg <= erase_next;
    end
  end

  assign pe.busy = (state_reg != PE_IDLE);
  assign pe.done = (state_reg == PE_FINISH);

endmodule

// ===== logic/fcpe_ctrl.sv
// Purpose: Flash access and program/erase control for several flash modules
// Assumes: Requests and configuration come from logic on the same clock
// Notes: Reads stall on wait states unless served by the prefetch word
// Notes on behaviour
// - Wait states are charged on every read the prefetch word does not serve; it serves a sequential read of the buffered next address.
// - A module may be programmed or erased only while it is not the one supplying code or data.
// - Program or erase of one module proceeds while reads continue from another module.
// - A sector or page erase finishes within 8.0 ms, typically about 7 ms.
// - A page program finishes within 3.5 ms, typically about 3 ms.
// - The sequencer adds a few system clock cycles beyond the flash operation time.
// - After reset every sector reads as erased and no protection is active.
module fcpe_ctrl
  import fcpe_pkg::*;
#(
  parameter int NUM_MODULES = 2,
  parameter int DEPTH = 64,
  parameter int PAGE = 8,
  parameter int DATA_W = 16,
  parameter int SYS_MHZ = CLK_MHZ,
  parameter int ERASE_CYC = ERASE_TYP_CYCLES,
  parameter int PROG_CYC = PROG_TYP_CYCLES,
  localparam int MOD_W = $clog2(NUM_MODULES),
  localparam int WORD_W = $clog2(DEPTH),
  localparam int PG_W = $clog2(DEPTH / PAGE),
  localparam int ADDR_W = MOD_W + WORD_W
)
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Configuration
  input wire logic [WS_W-1:0] flash_wait_state_count_in,
  output logic ws_too_low_out,
  // Read port
  input wire logic rd_valid_in,
  input wire logic rd_seq_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic rd_ready_out,
  output logic rsp_valid_out,
  output logic [DATA_W-1:0] rsp_data_out,
  // Program/erase port
  input wire logic pe_req_in,
  input wire logic pe_erase_in,
  input wire logic [MOD_W-1:0] pe_module_in,
  input wire logic [PG_W-1:0] pe_page_in,
  input wire logic [DATA_W-1:0] pe_data_in,
  output logic pe_accept_out,
  output logic pe_refused_out,
  output logic pe_busy_out,
  output logic pe_done_out
);

  // Elaboration-time refusal of sizes and times the logic cannot serve
  if (NUM_MODULES < 2 || (1 << MOD_W) != NUM_MODULES || (1 << WORD_W) != DEPTH ||
      PAGE < 1 || (DEPTH % PAGE) != 0 || (1 << PG_W) * PAGE != DEPTH)
  begin
    $error("fcpe_ctrl: module count, depth and page size must be powers of two");
  end
  if (ERASE_CYC + CTRL_OVERHEAD_CYCLES + 1 > ERASE_MAX_CYCLES || PROG_CYC + CTRL_OVERHEAD_CYCLES + 1 > PROG_MAX_CYCLES)
  begin
    $error("fcpe_ctrl: program/erase time exceeds its limit");
  end

  localparam int CELLS = NUM_MODULES * DEPTH;
  localparam int PW = $clog2(PAGE);

  fcpe_pe_if pe_if();

  fcpe_pe_seq #(
    .ERASE_CYC(ERASE_CYC),
    .PROG_CYC(PROG_CYC)
  ) u_seq (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .pe(pe_if.seq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Program/erase acceptance and flash array

  logic [DATA_W-1:0] mem_reg [CELLS];
  logic [DATA_W-1:0] mem_next [CELLS];
  logic [MOD_W-1:0] pe_mod_reg, pe_mod_next;
  logic [PG_W-1:0] pe_page_reg, pe_page_next;
  logic [DATA_W-1:0] pe_data_reg, pe_data_next;
  logic pe_erase_reg, pe_erase_next;
  logic [MOD_W-1:0] fetch_mod_reg, fetch_mod_next;
  logic fetch_seen_reg, fetch_seen_next;
  logic pe_conflict;
  logic pe_take;
  logic ws_low_reg, ws_low_next;

  // Refuse a request on the module that is supplying code or data
  assign pe_conflict = fetch_seen_reg && (pe_module_in == fetch_mod_reg);
  assign pe_take = pe_req_in && !pe_if.busy && !pe_conflict;
  assign pe_if.start = pe_take;
  assign pe_if.erase = pe_erase_in;

  always_comb
  begin
    mem_next = mem_reg;
    pe_mod_next = pe_mod_reg;
    pe_page_next = pe_page_reg;
    pe_data_next = pe_data_reg;
    pe_erase_next = pe_erase_reg;
    ws_low_next = flash_wait_state_count_in < fcpe_min_ws(SYS_MHZ);
    if (pe_take)
    begin
      pe_mod_next = pe_module_in;
      pe_page_next = pe_page_in;
      pe_data_next = pe_data_in;
      pe_erase_next = pe_erase_in;
    end
    if (pe_if.done)
    begin
      for (int i = 0; i < PAGE; i++)
      begin
        // Erase sets the page to ones, program can only clear bits
        if (pe_erase_reg)
        begin
          mem_next[{pe_mod_reg, pe_page_reg, PW'(i)}] = '1;
        end
        else
        begin
          mem_next[{pe_mod_reg, pe_page_reg, PW'(i)}] = mem_reg[{pe_mod_reg, pe_page_reg, PW'(i)}] & pe_data_reg;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      for (int i = 0; i < CELLS; i++)
      begin
        mem_reg[i] <= '1;
      end
      pe_mod_reg <= '0;
      pe_page_reg <= '0;
      pe_data_reg <= '1;
      pe_erase_reg <= 1'b0;
      ws_low_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      mem_reg <= mem_next;
      pe_mod_reg <= pe_mod_next;
      pe_page_reg <= pe_page_next;
      pe_data_reg <= pe_data_next;
      pe_erase_reg <= pe_erase_next;
      ws_low_reg <= ws_low_next;
    end
  end

  assign pe_accept_out = pe_take;
  assign pe_refused_out = pe_req_in && !pe_take;
  assign pe_busy_out = pe_if.busy;
  assign pe_done_out = pe_if.done;
  assign ws_too_low_out = ws_low_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path with prefetch

  fcpe_rd_state_type rd_state_reg, rd_state_next;
  logic [WS_W-1:0] ws_cnt_reg, ws_cnt_next;
  logic [DATA_W-1:0] rsp_data_reg, rsp_data_next;
  logic [ADDR_W-1:0] pf_addr_reg, pf_addr_next;
  logic [DATA_W-1:0] pf_data_reg, pf_data_next;
  logic pf_valid_reg, pf_valid_next;
  logic rd_blocked;
  logic rd_take;
  logic pf_hit;
  logic [ADDR_W-1:0] rd_addr_inc;

  // Reads to the module under program/erase wait; other modules run on
  assign rd_blocked = pe_if.busy && (rd_addr_in[ADDR_W-1 -: MOD_W] == pe_mod_reg);
  assign rd_ready_out = (rd_state_reg == RD_IDLE) && !rd_blocked;
  assign rd_take = rd_valid_in && rd_ready_out;
  assign pf_hit = rd_seq_in && pf_valid_reg && (rd_addr_in == pf_addr_reg);
  assign rd_addr_inc = rd_addr_in + 1'b1;

  always_comb
  begin
    rd_state_next = rd_state_reg;
    ws_cnt_next = ws_cnt_reg;
    rsp_data_next = rsp_data_reg;
    pf_addr_next = pf_addr_reg;
    pf_data_next = pf_data_reg;
    pf_valid_next = pf_valid_reg;
    fetch_mod_next = fetch_mod_reg;
    fetch_seen_next = fetch_seen_reg;
    case (rd_state_reg)
      RD_IDLE:
      begin
        if (rd_take)
        begin
          fetch_mod_next = rd_addr_in[ADDR_W-1 -: MOD_W];
          fetch_seen_next = 1'b1;
          rsp_data_next = pf_hit ? pf_data_reg : mem_reg[rd_addr_in];
          pf_addr_next = rd_addr_inc;
          pf_data_next = mem_reg[rd_addr_inc];
          pf_valid_next = 1'b1;
          ws_cnt_next = flash_wait_state_count_in;
          if (pf_hit || flash_wait_state_count_in == '0)
          begin
            rd_state_next = RD_RESP;
          end
          else
          begin
            rd_state_next = RD_WAIT;
          end
        end
      end
      RD_WAIT:
      begin
        if (ws_cnt_reg <= WS_W'(1))
        begin
          rd_state_next = RD_RESP;
        end
        else
        begin
          ws_cnt_next = ws_cnt_reg - 1'b1;
        end
      end
      RD_RESP:
      begin
        rd_state_next = RD_IDLE;
      end
      default:
      begin
        rd_state_next = RD_IDLE;
      end
    endcase
    // A finished program/erase makes a buffered word of that module stale
    if (pe_if.done && pf_addr_reg[ADDR_W-1 -: MOD_W] == pe_mod_reg)
    begin
      pf_valid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rd_state_reg <= RD_IDLE;
      ws_cnt_reg <= '0;
      rsp_data_reg <= '0;
      pf_addr_reg <= '0;
      pf_data_reg <= '0;
      pf_valid_reg <= 1'b0;
      fetch_mod_reg <= '0;
      fetch_seen_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      rd_state_reg <= rd_state_next;
      ws_cnt_reg <= ws_cnt_next;
      rsp_data_reg <= rsp_data_next;
      pf_addr_reg <= pf_addr_next;
      pf_data_reg <= pf_data_next;
      pf_valid_reg <= pf_valid_next;
      fetch_mod_reg <= fetch_mod_next;
      fetch_seen_reg <= fetch_seen_next;
    end
  end

  assign rsp_valid_out = (rd_state_reg == RD_RESP);
  assign rsp_data_out = rsp_data_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [CNT_W-1:0] pe_elapsed_reg;
  logic [WS_W:0] rd_lat_reg;
  logic [WS_W:0] rd_exp_reg;
  logic booted_reg;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pe_elapsed_reg <= '0;
      rd_lat_reg <= '0;
      rd_exp_reg <= '0;
      booted_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      booted_reg <= 1'b1;
      pe_elapsed_reg <= pe_take ? '0 : (pe_if.busy ? pe_elapsed_reg + 1'b1 : pe_elapsed_reg);
      rd_lat_reg <= rd_take ? (WS_W + 1)'(1) : rd_lat_reg + 1'b1;
      if (rd_take)
      begin
        rd_exp_reg <= pf_hit ? (WS_W + 1)'(1) : ((WS_W + 1)'(flash_wait_state_count_in) + 1'b1);
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in || !ce_in);

  chk_seq_no_wait: assert property (rd_take && pf_hit |=> rsp_valid_out)
    else $error("sequential prefetch hit was not answered in the next cycle");
  chk_nonseq_latency: assert property (rsp_valid_out |-> rd_lat_reg == rd_exp_reg)
    else $error("read answer latency differs from the wait-state count");
  chk_nonseq_bound: assert property (rd_take && !pf_hit |-> ##[1:8] rsp_valid_out)
    else $error("non-sequential read not answered within eight cycles");
  chk_serving_refused: assert property (pe_req_in && pe_conflict |-> !pe_accept_out && pe_refused_out)
    else $error("program/erase accepted on the module supplying reads");
  chk_no_read_busy: assert property (rd_take |-> !(pe_if.busy && rd_addr_in[ADDR_W-1 -: MOD_W] == pe_mod_reg))
    else $error("read taken from the module under program/erase");
  chk_other_module_runs: assert property (rd_valid_in && rd_state_reg == RD_IDLE && pe_if.busy &&
    rd_addr_in[ADDR_W-1 -: MOD_W] != pe_mod_reg |-> rd_ready_out)
    else $error("read of an idle module stalled during program/erase");
  chk_erase_time: assert property (pe_if.done && pe_erase_reg |-> pe_elapsed_reg + 1 <= ERASE_MAX_CYCLES)
    else $error("erase exceeded its maximum time");
  chk_prog_time: assert property (pe_if.done && !pe_erase_reg |-> pe_elapsed_reg + 1 <= PROG_MAX_CYCLES)
    else $error("program exceeded its maximum time");
  chk_ctrl_overhead: assert property (pe_if.done |->
    pe_elapsed_reg == CNT_W'((pe_erase_reg ? ERASE_CYC : PROG_CYC) + CTRL_OVERHEAD_CYCLES))
    else $error("sequencer overhead differs from its fixed cycle count");
  chk_erased_start: assert property (!booted_reg |-> mem_reg[0] == '1 && mem_reg[CELLS-1] == '1 && !pe_if.busy)
    else $error("flash not erased and idle after reset");

  cov_prefetch_hit: cover property (rd_take && pf_hit ##1 rsp_valid_out);
  cov_read_during_pe: cover property (pe_if.busy && rd_take);
  cov_erase_done: cover property (pe_if.done && pe_erase_reg);
  cov_refused: cover property (pe_req_in && pe_conflict);

endmodule

// ===== testbench/fcpe_fetch_model.sv
// Purpose: Processor fetch path model that issues single-word flash reads
// Assumes: One read outstanding; the request is held until ready is seen
// Notes: Idle address and sequence lines show the inverse of the last value
module fcpe_fetch_model
  import fcpe_pkg::*;
#(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 16
)
(
  // Clock
  input wire logic clk_in,
  // Request side
  output logic rd_valid_out,
  output logic rd_seq_out,
  output logic [ADDR_W-1:0] rd_addr_out,
  input wire logic rd_ready_in,
  // Response side
  input wire logic rsp_valid_in,
  input wire logic [DATA_W-1:0] rsp_data_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    rd_valid_out = 1'b0;
    rd_seq_out = 1'b0;
    rd_addr_out = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One read; gap idle cycles first, lat counts cycles after the take
  task automatic read(input logic [ADDR_W-1:0] addr, input logic seq, input int gap,
                      output int lat, output logic [DATA_W-1:0] data);
    int n;
    lat = -1;
    data = '0;
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    #1;
    rd_valid_out = 1'b1;
    rd_seq_out = seq;
    rd_addr_out = addr;
    n = 0;
    while (n < 300)
    begin
      @(posedge clk_in);
      if (rd_ready_in === 1'b1) break;
      n++;
    end
    #1;
    rd_valid_out = 1'b0;
    rd_seq_out = ~seq;
    rd_addr_out = ~addr;
    if (n >= 300) return;
    n = 1;
    while (n < 300)
    begin
      if (rsp_valid_in === 1'b1)
      begin
        lat = n;
        data = rsp_data_in;
        break;
      end
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask
endmodule

// ===== testbench/flash_access_and_program_control_tb.sv
// Purpose: Self-checking bench for the flash access and program/erase control
// Assumes: Short program and erase counts stand in for the long flash times
// Notes: Read rows first, then program/erase, conflict and reset cases
module flash_access_and_program_control_tb
  import fcpe_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int PROG_N = 10;
  localparam int ERASE_N = 20;
  typedef struct {logic [2:0] ws; logic seq; logic [6:0] addr; logic hit;} fcpe_row_type;
  fcpe_row_type rows [10] = '{'{3'h4, 1'b0, 7'h00, 1'b0}, '{3'h4, 1'b1, 7'h01, 1'b1},
    '{3'h4, 1'b1, 7'h02, 1'b1}, '{3'h3, 1'b1, 7'h04, 1'b0}, '{3'h2, 1'b0, 7'h05, 1'b0},
    '{3'h2, 1'b1, 7'h06, 1'b1}, '{3'h0, 1'b0, 7'h14, 1'b0}, '{3'h7, 1'b0, 7'h43, 1'b0},
    '{3'h7, 1'b1, 7'h44, 1'b1}, '{3'h5, 1'b0, 7'h09, 1'b0}};

  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ce = 1'b1;
  logic [2:0] ws = 3'h4;
  logic ws_low, rd_valid, rd_seq, rd_ready, rsp_valid, pe_accept, pe_refused, pe_busy, pe_done;
  logic [6:0] rd_addr;
  logic [15:0] rsp_data;
  logic pe_req = 1'b0;
  logic pe_erase = 1'b0;
  logic pe_module = 1'b0;
  logic [2:0] pe_page = 3'h0;
  logic [15:0] pe_data = 16'hFFFF;
  int err_count = 0;
  int check_count = 0;

  always #5 clk_in = ~clk_in;

  fcpe_ctrl #(.ERASE_CYC(ERASE_N), .PROG_CYC(PROG_N)) dut_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce),
    .flash_wait_state_count_in(ws), .ws_too_low_out(ws_low),
    .rd_valid_in(rd_valid), .rd_seq_in(rd_seq), .rd_addr_in(rd_addr), .rd_ready_out(rd_ready),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
    .pe_req_in(pe_req), .pe_erase_in(pe_erase), .pe_module_in(pe_module), .pe_page_in(pe_page),
    .pe_data_in(pe_data), .pe_accept_out(pe_accept), .pe_refused_out(pe_refused),
    .pe_busy_out(pe_busy), .pe_done_out(pe_done));

  fcpe_fetch_model #(.ADDR_W(7), .DATA_W(16)) model_u (
    .clk_in(clk_in), .rd_valid_out(rd_valid), .rd_seq_out(rd_seq), .rd_addr_out(rd_addr),
    .rd_ready_in(rd_ready), .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data));

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s: got %0h, expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic rd(input logic [6:0] a, input logic s, input int gap, input int lat_exp,
                    input logic [15:0] d_exp);
    int lat;
    logic [15:0] d;
    model_u.read(a, s, gap, lat, d);
    check(lat, lat_exp, "read latency");
    check(d, d_exp, "read data");
    if (lat < 0) end_sim();
  endtask

  // Program/erase request; exp_n is the cycle count from take to done
  task automatic pe(input logic m, input logic er, input logic [2:0] pg, input logic [15:0] dat,
                    input logic ok, input int exp_n);
    int n;
    @(posedge clk_in);
    #1;
    pe_req = 1'b1;
    pe_erase = er;
    pe_module = m;
    pe_page = pg;
    pe_data = dat;
    @(posedge clk_in);
    check(pe_accept, ok, "accept");
    check(pe_refused, !ok, "refused");
    #1;
    pe_req = 1'b0;
    pe_data = ~dat;
    n = 0;
    while (ok && n < 300)
    begin
      n++;
      if (n == 1) check(pe_busy, 1'b1, "busy");
      if (pe_done === 1'b1) break;
      @(posedge clk_in);
      #1;
    end
    if (ok) check(n, exp_n, "duration");
    if (n >= 300) end_sim();
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      ws = rows[i].ws;
      rd(rows[i].addr, rows[i].seq, i % 2, rows[i].hit ? 1 : int'(rows[i].ws) + 1, 16'hFFFF);
      check(ws_low, rows[i].ws < WS_MIN_4, "wait flag");
    end
    ws = 3'h4;
    pe(1'b0, 1'b0, 3'h0, 16'h0000, 1'b0, 0);
    fork
      pe(1'b1, 1'b0, 3'h0, 16'h5A5A, 1'b1, CTRL_OVERHEAD_CYCLES + PROG_N + 1);
      rd(7'h0A, 1'b0, 2, 5, 16'hFFFF);
    join
    rd(7'h40, 1'b0, 1, 5, 16'h5A5A);
    pe(1'b0, 1'b0, 3'h1, 16'h0F0F, 1'b1, CTRL_OVERHEAD_CYCLES + PROG_N + 1);
    rd(7'h08, 1'b0, 0, 5, 16'h0F0F);
    rd(7'h47, 1'b0, 1, 5, 16'h5A5A);
    pe(1'b0, 1'b1, 3'h1, 16'h0000, 1'b1, CTRL_OVERHEAD_CYCLES + ERASE_N + 1);
    rd(7'h08, 1'b0, 0, 5, 16'hFFFF);
    rd(7'h09, 1'b1, 0, 1, 16'hFFFF);
    // A read of the module under erase stalls and then sees the erased page
    fork
      pe(1'b1, 1'b1, 3'h0, 16'h0000, 1'b1, CTRL_OVERHEAD_CYCLES + ERASE_N + 1);
      rd(7'h41, 1'b0, 2, 5, 16'hFFFF);
    join
    // A low clock enable freezes the wait-state count for three cycles
    fork
      rd(7'h10, 1'b0, 0, 8, 16'hFFFF);
      begin
        repeat (2) @(posedge clk_in);
        #1;
        ce = 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        ce = 1'b1;
      end
    join
    // Reset while no read or program/erase is running brings every sector back to erased
    nrst_in = 1'b0;
    repeat (2) @(posedge clk_in);
    check(rsp_valid, 1'b0, "reset valid");
    check(pe_busy, 1'b0, "reset busy");
    #1;
    nrst_in = 1'b1;
    pe(1'b1, 1'b0, 3'h2, 16'h00FF, 1'b1, CTRL_OVERHEAD_CYCLES + PROG_N + 1);
    rd(7'h40, 1'b0, 0, 5, 16'hFFFF);
    rd(7'h50, 1'b0, 1, 5, 16'h00FF);
    end_sim();
  end
endmodule
